// file: hw/rsos_pkg.sv
package rsos_pkg;

	localparam int SEL_W    = 7;
	localparam int NUM_PINS = 6;
	localparam int CNT_W    = 8;
	localparam int STATE_W  = 6;
	localparam int SRC_N    = 128;

	// Pin output select codes.
	localparam logic [SEL_W-1:0] SEL_FIFOP      = 7'h28;
	localparam logic [SEL_W-1:0] SEL_CCA        = 7'h29;
	localparam logic [SEL_W-1:0] SEL_SFD        = 7'h2A;
	localparam logic [SEL_W-1:0] SEL_LOCK       = 7'h2B;
	localparam logic [SEL_W-1:0] SEL_RSSI_VALID = 7'h2C;
	localparam logic [SEL_W-1:0] SEL_SAMPLED_CCA = 7'h2D;
	localparam logic [SEL_W-1:0] SEL_RAND_I     = 7'h2E;
	localparam logic [SEL_W-1:0] SEL_RAND_Q     = 7'h2F;
	localparam logic [SEL_W-1:0] SEL_RAND_XOR   = 7'h30;
	localparam logic [SEL_W-1:0] SEL_SNIFF_CLK  = 7'h31;
	localparam logic [SEL_W-1:0] SEL_SNIFF_DATA = 7'h32;
	localparam logic [SEL_W-1:0] SEL_MOD_CLK    = 7'h33;
	localparam logic [SEL_W-1:0] SEL_MOD_DATA   = 7'h34;
	localparam logic [SEL_W-1:0] SEL_RX_ACTIVE  = 7'h43;
	localparam logic [SEL_W-1:0] SEL_TX_ACTIVE  = 7'h44;
	localparam logic [SEL_W-1:0] SEL_DPU_BUSY_L = 7'h5E;
	localparam logic [SEL_W-1:0] SEL_DPU_BUSY_H = 7'h5F;
	localparam logic [SEL_W-1:0] SEL_DPU_PEND_L = 7'h62;
	localparam logic [SEL_W-1:0] SEL_DPU_PEND_H = 7'h63;
	localparam logic [SEL_W-1:0] SEL_ZERO       = 7'h7E;
	localparam logic [SEL_W-1:0] SEL_ONE        = 7'h7F;

	// Frame control state encodings that count as receive or transmit.
	localparam logic [STATE_W-1:0] RX_STATE_FIRST = 6'h06;
	localparam logic [STATE_W-1:0] RX_STATE_LAST  = 6'h1F;
	localparam logic [STATE_W-1:0] TX_STATE_FIRST = 6'h20;
	localparam logic [STATE_W-1:0] TX_STATE_LAST  = 6'h2F;

	// Serial clock timing for the sniffer and modulator outputs.
	localparam int MCLK_HZ    = 10_000_000;
	localparam int SER_CLK_HZ = 250_000;
	localparam int SER_HALF_CYC = MCLK_HZ / (2 * SER_CLK_HZ);
	localparam int DIV_W      = 5;

	localparam logic SER_CLK_RST = 1'b0;
	localparam logic FLAG_RST    = 1'b0;

endpackage

// file: hw/rsos_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none

module rsos_pin_mux
	import rsos_pkg::*;
#(
	parameter int SRC_W = SRC_N
) (
	input  wire logic [SEL_W-1:0] i_sel,
	input  wire logic [SRC_W-1:0] i_src,
	output logic                  o_pin
);

	// Unused codes index table entries tied low, so nothing undefined leaks.
	assign o_pin = i_src[i_sel];

endmodule // rsos_pin_mux

`default_nettype wire

// file: hw/rsos_selector.sv
`timescale 1ns/1ps
`default_nettype none

module rsos_selector
	import rsos_pkg::*;
#(
	parameter int PINS = NUM_PINS,
	parameter int CW   = CNT_W
) (
	input  wire logic                   i_mclk,
	input  wire logic                   i_sys_rst,
	input  wire logic [PINS*SEL_W-1:0]  i_pin_sel,
	input  wire logic [CW-1:0]          i_rxbuf_count,
	input  wire logic [CW-1:0]          i_fifop_thr,
	input  wire logic                   i_rxbuf_frame,
	input  wire logic                   i_rxbuf_ovf,
	input  wire logic                   i_cca,
	input  wire logic [STATE_W-1:0]     i_fsm_state,
	input  wire logic                   i_sfd_stb,
	input  wire logic                   i_synth_lock,
	input  wire logic                   i_rssi_upd_stb,
	input  wire logic                   i_cca_demod,
	input  wire logic                   i_sample_cca_stb,
	input  wire logic                   i_tx_if_clear_stb,
	input  wire logic                   i_rand_i,
	input  wire logic                   i_rand_q,
	input  wire logic                   i_rand_stb,
	input  wire logic                   i_sniff_data,
	input  wire logic                   i_mod_data,
	input  wire logic [1:0]             i_dpu_busy,
	input  wire logic [1:0]             i_dpu_pend,
	output logic                        o_ser_bit_take,
	output logic [PINS-1:0]             o_pin
);

	function automatic logic in_range(input logic [STATE_W-1:0] s,
			input logic [STATE_W-1:0] lo, input logic [STATE_W-1:0] hi);
		in_range = (s >= lo) && (s <= hi);
	endfunction

	// Activity decode is combinational from the state register.
	wire rx_active = in_range(i_fsm_state, RX_STATE_FIRST,
			RX_STATE_LAST);
	wire tx_active = in_range(i_fsm_state, TX_STATE_FIRST,
			TX_STATE_LAST);

	logic rx_q;
	logic tx_q;
	logic fifop;
	logic sfd;
	logic rssi_valid;
	logic sampled_cca;
	logic rand_i;
	logic rand_q;
	logic ser_clk;
	logic sniff_bit;
	logic mod_bit;
	logic [DIV_W-1:0] div_cnt;

	wire leave_rx  = rx_q && !rx_active;
	wire leave_tx  = tx_q && !tx_active;
	wire next_fifop = (i_rxbuf_count > i_fifop_thr) || i_rxbuf_frame
			|| i_rxbuf_ovf;
	// A new event in the clearing cycle wins over the clear.
	wire sfd_set   = i_sfd_stb && (rx_active || tx_active);
	wire next_sfd  = sfd_set ? 1'b1 : ((leave_rx || leave_tx) ? 1'b0 : sfd);
	wire rssi_set  = i_rssi_upd_stb && rx_active;
	wire next_rssi_valid = rssi_set ? 1'b1 :
			(leave_rx ? 1'b0 : rssi_valid);
	wire cca_take  = i_sample_cca_stb || i_tx_if_clear_stb;
	wire div_wrap  = (div_cnt == DIV_W'(SER_HALF_CYC - 1));
	// Data is taken on the falling edge so it is steady at the rising one.
	wire ser_fall  = div_wrap && ser_clk;

	assign o_ser_bit_take = ser_fall;

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rx_q <= FLAG_RST;
			tx_q <= FLAG_RST;
			fifop <= FLAG_RST;
			sfd <= FLAG_RST;
			rssi_valid <= FLAG_RST;
			sampled_cca <= FLAG_RST;
		end else begin
			rx_q <= rx_active;
			tx_q <= tx_active;
			fifop <= next_fifop;
			sfd <= next_sfd;
			rssi_valid <= next_rssi_valid;
			if (cca_take) begin
				sampled_cca <= i_cca_demod;
			end
		end
	end

	// Random bits are refreshed on each receiver sample strobe.
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rand_i <= FLAG_RST;
			rand_q <= FLAG_RST;
		end else if (i_rand_stb) begin
			rand_i <= i_rand_i;
			rand_q <= i_rand_q;
		end
	end

	// One divider serves both 250kHz serial clocks.
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			div_cnt <= '0;
			ser_clk <= SER_CLK_RST;
		end else if (div_wrap) begin
			div_cnt <= '0;
			ser_clk <= !ser_clk;
		end else begin
			div_cnt <= div_cnt + DIV_W'(1);
		end
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sniff_bit <= FLAG_RST;
			mod_bit <= FLAG_RST;
		end else if (ser_fall) begin
			sniff_bit <= i_sniff_data;
			mod_bit <= i_mod_data;
		end
	end

	// Source table; every entry not assigned below stays low.
	logic [SRC_N-1:0] src;
	always_comb begin
		src = '0;
		src[SEL_FIFOP] = fifop;
		src[SEL_CCA] = i_cca;
		src[SEL_SFD] = sfd;
		src[SEL_LOCK] = i_synth_lock;
		src[SEL_RSSI_VALID] = rssi_valid;
		src[SEL_SAMPLED_CCA] = sampled_cca;
		src[SEL_RAND_I] = rand_i;
		src[SEL_RAND_Q] = rand_q;
		src[SEL_RAND_XOR] = rand_i ^ rand_q;
		src[SEL_SNIFF_CLK] = ser_clk;
		src[SEL_SNIFF_DATA] = sniff_bit;
		src[SEL_MOD_CLK] = ser_clk;
		src[SEL_MOD_DATA] = mod_bit;
		src[SEL_RX_ACTIVE] = rx_active;
		src[SEL_TX_ACTIVE] = tx_active;
		src[SEL_DPU_BUSY_L] = i_dpu_busy[0];
		src[SEL_DPU_BUSY_H] = i_dpu_busy[1];
		src[SEL_DPU_PEND_L] = i_dpu_pend[0];
		src[SEL_DPU_PEND_H] = i_dpu_pend[1];
		src[SEL_ZERO] = 1'b0;
		src[SEL_ONE] = 1'b1;
	end

	for (genvar g = 0; g < PINS; g++) begin : g_pin
		rsos_pin_mux #(.SRC_W(SRC_N)) rsos_pin_mux_inst (
			.i_sel (i_pin_sel[g*SEL_W +: SEL_W]),
			.i_src (src),
			.o_pin (o_pin[g])
		);
	end

	wire [SEL_W-1:0] sel0 = i_pin_sel[SEL_W-1:0];

	property p_fifop_ovf;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(sel0 == SEL_FIFOP && i_rxbuf_ovf) |=> (sel0 != SEL_FIFOP || o_pin[0]);
	endproperty
	a_fifop_ovf: assert property (p_fifop_ovf)
		else $error("fifop pin low after overflow");

	property p_cca;
		@(posedge i_mclk) disable iff (i_sys_rst)
		sel0 == SEL_CCA |-> o_pin[0] == i_cca;
	endproperty
	a_cca: assert property (p_cca)
		else $error("cca pin does not follow channel clear");
	property p_sfd_set;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(i_sfd_stb && rx_active) |=> sfd;
	endproperty
	a_sfd_set: assert property (p_sfd_set)
		else $error("sfd flag not set by delimiter strobe");
	property p_sfd_clr;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(rx_q && !rx_active && !tx_active && !i_sfd_stb) |=> !sfd;
	endproperty
	a_sfd_clr: assert property (p_sfd_clr)
		else $error("sfd flag not cleared on leaving receive");

	property p_lock;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(sel0 == SEL_LOCK) |-> o_pin[0] == i_synth_lock;
	endproperty
	a_lock: assert property (p_lock)
		else $error("lock pin mismatch");
	property p_rssi;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(i_rssi_upd_stb && rx_active) ##1 rx_active[*2] |-> rssi_valid;
	endproperty
	a_rssi: assert property (p_rssi)
		else $error("rssi_valid lost while still in receive");
	property p_sampled_cca;
		@(posedge i_mclk) disable iff (i_sys_rst)
		cca_take |=> sampled_cca == $past(i_cca_demod);
	endproperty
	a_sampled_cca: assert property (p_sampled_cca)
		else $error("sampled cca not latched on strobe");

	property p_rand;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(!i_rand_stb ##1 (sel0 == SEL_RAND_XOR)) |->
			o_pin[0] == ($past(rand_i) ^ $past(rand_q));
	endproperty
	a_rand: assert property (p_rand)
		else $error("random output changed without strobe or bad xor");

	logic [DIV_W-1:0] hi_len;
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			hi_len <= '0;
		end else begin
			hi_len <= ser_clk ? hi_len + DIV_W'(1) : '0;
		end
	end
	property p_ser_clk;
		@(posedge i_mclk) disable iff (i_sys_rst)
		$fell(ser_clk) |-> hi_len == DIV_W'(SER_HALF_CYC);
	endproperty
	a_ser_clk: assert property (p_ser_clk)
		else $error("serial clock high phase not 20 cycles");
	property p_ser_data;
		@(posedge i_mclk) disable iff (i_sys_rst)
		ser_clk && !$past(ser_clk) |-> $stable(sniff_bit) && $stable(mod_bit);
	endproperty
	a_ser_data: assert property (p_ser_data)
		else $error("serial data moved at rising clock");

	property p_rx_act;
		@(posedge i_mclk) disable iff (i_sys_rst)
		sel0 == SEL_RX_ACTIVE |-> o_pin[0] == (i_fsm_state >= RX_STATE_FIRST
			&& i_fsm_state <= RX_STATE_LAST);
	endproperty
	a_rx_act: assert property (p_rx_act)
		else $error("rx_active pin mismatch");
	property p_tx_act;
		@(posedge i_mclk) disable iff (i_sys_rst)
		sel0 == SEL_TX_ACTIVE |-> o_pin[0] == (i_fsm_state >= TX_STATE_FIRST
			&& i_fsm_state <= TX_STATE_LAST);
	endproperty
	a_tx_act: assert property (p_tx_act)
		else $error("tx_active pin mismatch");
	property p_dpu;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(sel0 == SEL_DPU_BUSY_H |-> o_pin[0] == i_dpu_busy[1]) and
		(sel0 == SEL_DPU_PEND_L |-> o_pin[0] == i_dpu_pend[0]);
	endproperty
	a_dpu: assert property (p_dpu)
		else $error("processing unit status pin mismatch");
	property p_const;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(sel0 == SEL_ONE |-> o_pin[0]) and (sel0 == SEL_ZERO |-> !o_pin[0]);
	endproperty
	a_const: assert property (p_const)
		else $error("constant pin level wrong");

	property p_reserved;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(sel0 > SEL_MOD_DATA && sel0 < SEL_RX_ACTIVE) |-> !o_pin[0];
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved code drives pin high");

endmodule // rsos_selector

`default_nettype wire

// file: tb/rsos_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module rsos_host_model (
	input  wire logic i_mclk,
	input  wire logic i_clk_pin,
	input  wire logic i_dat_pin,
	output logic      o_cap_stb,
	output logic      o_cap_bit
);
	logic prev;

	// The data pin is taken every cycle; the strobe marks a rising edge of the clock pin.
	always_ff @(posedge i_mclk) begin
		prev      <= i_clk_pin;
		o_cap_stb <= i_clk_pin & ~prev;
		o_cap_bit <= i_dat_pin;
	end
endmodule // rsos_host_model

`default_nettype wire

// file: tb/rsos_selector_tb.sv
`timescale 1ns/1ps
`default_nettype none

module radio_status_output_selector_tb_top
	import rsos_pkg::*;
;
	logic               i_mclk = 1'b0;
	logic               i_sys_rst = 1'b1;
	logic [SEL_W-1:0]   sel0 = SEL_ZERO;
	logic [CNT_W-1:0]   cnt = 8'h00, thr = 8'h00;
	logic               frm = 1'b0, ovf = 1'b0, dm = 1'b0;
	logic               ri = 1'b0, rq = 1'b0, ls = 1'b0, lm = 1'b0;
	logic [5:0]         lv = 6'h00;
	logic [STATE_W-1:0] fsm = 6'h00;
	logic [4:0]         p = 5'h00;
	logic [7:0]         sr = 8'hC5;
	logic               ser_on = 1'b0, seen = 1'b0, take;
	logic [NUM_PINS-1:0] o_pin;
	logic               hs_stb, hs_bit, hm_stb, hm_bit;
	int                 failures = 0, check_count = 0;
	int                 cyc = 0, gap = 0, ncap = 0;
	wire logic [NUM_PINS*SEL_W-1:0] psel = {SEL_RAND_XOR, SEL_MOD_DATA,
		SEL_MOD_CLK, SEL_SNIFF_DATA, SEL_SNIFF_CLK, sel0};

	// Rows hold code, level inputs, state and the expected pin level.
	localparam logic [19:0] LT [18] = '{
		{SEL_CCA, 6'h01, 6'h00, 1'b1}, {SEL_CCA, 6'h3E, 6'h00, 1'b0},
		{SEL_LOCK, 6'h02, 6'h00, 1'b1}, {SEL_LOCK, 6'h3D, 6'h00, 1'b0},
		{SEL_RX_ACTIVE, 6'h00, 6'h06, 1'b1},
		{SEL_RX_ACTIVE, 6'h00, 6'h05, 1'b0},
		{SEL_RX_ACTIVE, 6'h00, 6'h1F, 1'b1},
		{SEL_TX_ACTIVE, 6'h00, 6'h20, 1'b1},
		{SEL_TX_ACTIVE, 6'h00, 6'h2F, 1'b1},
		{SEL_TX_ACTIVE, 6'h00, 6'h30, 1'b0},
		{SEL_DPU_BUSY_L, 6'h3B, 6'h00, 1'b0},
		{SEL_DPU_BUSY_H, 6'h08, 6'h00, 1'b1},
		{SEL_DPU_PEND_L, 6'h10, 6'h00, 1'b1},
		{SEL_DPU_PEND_H, 6'h1F, 6'h00, 1'b0},
		{SEL_ZERO, 6'h3F, 6'h00, 1'b0}, {SEL_ONE, 6'h00, 6'h00, 1'b1},
		{7'h00, 6'h3F, 6'h00, 1'b0}, {7'h35, 6'h3F, 6'h00, 1'b0}};

	rsos_selector rsos_selector_inst (
		.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_pin_sel(psel),
		.i_rxbuf_count(cnt), .i_fifop_thr(thr), .i_rxbuf_frame(frm),
		.i_rxbuf_ovf(ovf), .i_cca(lv[0]), .i_fsm_state(fsm),
		.i_sfd_stb(p[0]), .i_synth_lock(lv[1]), .i_rssi_upd_stb(p[1]),
		.i_cca_demod(dm), .i_sample_cca_stb(p[2]),
		.i_tx_if_clear_stb(p[3]), .i_rand_i(ri), .i_rand_q(rq),
		.i_rand_stb(p[4]), .i_sniff_data(sr[7]), .i_mod_data(sr[3]),
		.i_dpu_busy(lv[3:2]), .i_dpu_pend(lv[5:4]),
		.o_ser_bit_take(take), .o_pin(o_pin));

	rsos_host_model hs_inst (.i_mclk(i_mclk), .i_clk_pin(o_pin[1]),
		.i_dat_pin(o_pin[2]), .o_cap_stb(hs_stb), .o_cap_bit(hs_bit));
	rsos_host_model hm_inst (.i_mclk(i_mclk), .i_clk_pin(o_pin[3]),
		.i_dat_pin(o_pin[4]), .o_cap_stb(hm_stb), .o_cap_bit(hm_bit));

	task chk(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t pin level wrong", $time);
		end
	endtask

	task close_out;
		$display("failures=%0d checks=%0d", failures, check_count);
		if (failures == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task tick;
		@(posedge i_mclk);
	endtask

	// Pulses last one cycle: they are dropped at the edge that takes them.
	task rd(input logic e);
		@(posedge i_mclk);
		p <= 5'h00;
		#1;
		chk(o_pin[0], e);
	endtask

	task t_level;
		for (int k = 0; k < 18; k++) begin
			tick;
			sel0 <= LT[k][19:13];
			lv <= LT[k][12:7];
			fsm <= LT[k][6:1];
			#1;
			if (k < 10)
				chk(o_pin[0], LT[k][0]);
			else
				chk(o_pin[0], LT[k][0]);
		end
	endtask

	task t_fifop;
		tick;
		sel0 <= SEL_FIFOP;
		cnt <= 8'h10;
		thr <= 8'h10;
		rd(1'b0);
		tick;
		cnt <= 8'h11;
		rd(1'b1);
		tick;
		cnt <= 8'h00;
		frm <= 1'b1;
		rd(1'b1);
		tick;
		frm <= 1'b0;
		ovf <= 1'b1;
		rd(1'b1);
		tick;
		ovf <= 1'b0;
		rd(1'b0);
	endtask

	task t_evt;
		tick;
		sel0 <= SEL_SFD;
		p <= 5'h01;
		rd(1'b0);
		for (int k = 0; k < 2; k++) begin
			tick;
			fsm <= (k != 0) ? 6'h20 : 6'h06;
			p <= 5'h01;
			rd(1'b1);
			tick;
			fsm <= 6'h00;
			tick;
			rd(1'b0);
		end
		tick;
		sel0 <= SEL_RSSI_VALID;
		fsm <= 6'h1F;
		rd(1'b0);
		tick;
		p <= 5'h02;
		rd(1'b1);
		rd(1'b1);
		tick;
		fsm <= 6'h20;
		tick;
		rd(1'b0);
	endtask

	task t_samp;
		tick;
		sel0 <= SEL_SAMPLED_CCA;
		dm <= 1'b1;
		p <= 5'h04;
		rd(1'b1);
		tick;
		dm <= 1'b0;
		rd(1'b1);
		tick;
		p <= 5'h08;
		rd(1'b0);
		tick;
		sel0 <= SEL_RAND_I;
		ri <= 1'b1;
		p <= 5'h10;
		rd(1'b1);
		chk(o_pin[5], 1'b1);
		tick;
		sel0 <= SEL_RAND_Q;
		rq <= 1'b1;
		rd(1'b0);
		tick;
		p <= 5'h10;
		rd(1'b1);
		chk(o_pin[5], 1'b0);
		tick;
		sel0 <= SEL_RAND_XOR;
		rd(1'b0);
	endtask

	task t_ser;
		tick;
		ser_on <= 1'b1;
		repeat (400) tick;
		#1;
		chk(ncap > 8, 1'b1);
	endtask

	// Serial source, host-side checks and the run ceiling.
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		gap <= gap + 1;
		if (take === 1'b1) begin
			sr <= {sr[6:0], sr[7]};
			ls <= sr[7];
			lm <= sr[3];
		end
		if (ser_on && hs_stb === 1'b1) begin
			chk(hs_bit, ls);
			chk(hm_bit, lm);
			chk(hm_stb, 1'b1);
			if (seen)
				chk(gap == 39, 1'b1);
			seen <= 1'b1;
			gap <= 0;
			ncap <= ncap + 1;
		end
		if (cyc == 3000) begin
			failures++;
			close_out;
		end
	end

	initial begin
		forever #50 i_mclk = ~i_mclk;
	end

	initial begin
		repeat (16) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		t_level;
		t_fifop;
		t_evt;
		t_samp;
		t_ser;
		close_out;
	end
endmodule // radio_status_output_selector_tb_top

`default_nettype wire
